// file: rtl/capture_pulse_timer_defines.vh
`ifndef CAPTURE_PULSE_TIMER_DEFINES_VH
`define CAPTURE_PULSE_TIMER_DEFINES_VH
// register byte offsets
`define OFS_RUN        8'h00
`define OFS_FFCR       8'h04
`define OFS_MODE       8'h08
`define OFS_CMPA       8'h0C
`define OFS_CMPB       8'h10
`define OFS_CAPA       8'h14
`define OFS_CAPB       8'h18
`define OFS_COUNT      8'h1C
`define OFS_STATUS     8'h20
// run register fields
`define RUN_CNT_BIT    0
`define RUN_PRE_BIT    2
`define RUN_DBUF_BIT   7
// toggle-control fields
`define FFCR_CMD_LO    0
`define FFCR_CMD_HI    1
`define FFCR_TGA_BIT   2
`define FFCR_TGB_BIT   3
`define FFCR_TGCAP_BIT 4
`define FFCR_CMD_SET   2'h1
`define FFCR_CMD_CLR   2'h2
// mode register fields
`define MODE_CLK_LO    0
`define MODE_CLK_HI    1
`define MODE_CLE_BIT   2
`define MODE_SWCAP_BIT 3
`define MODE_TRIG_BIT  4
// clock source encodings
`define CLK_EXT        2'h0
`define CLK_T1         2'h1
`define CLK_T4         2'h2
`define CLK_T16        2'h3
// reset values
`define RST_RUN        8'h00
`define RST_FFCR       8'h03
`define RST_MODE       8'h00
`define RST_CMP        16'hFFFF
// axi responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
// prescaler finest tap divide (aclk cycles)
`define PRE_T1_DIV     8
`endif

// file: rtl/input_sync_edge.v
`timescale 1ns/100ps
// two-flop synchroniser with rising edge detect
module input_sync_edge (
  aclk,
  aresetn,
  pin_in,
  level,
  rise
);
  input  wire aclk;
  input  wire aresetn;
  input  wire pin_in;
  output reg  level;
  output wire rise;

  reg meta_r;
  reg prev_r;

  // meta_r read only by level
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      level  <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      level  <= meta_r;
      prev_r <= level;
    end
  end

  assign rise = level & ~prev_r;
endmodule // input_sync_edge

// file: rtl/prescaler_taps.v
`timescale 1ns/100ps
`include "capture_pulse_timer_defines.vh"
// prescaler giving one-cycle tick enables at /1, /4, /16 of the base tap
module prescaler_taps #(
  parameter BASE_DIV = `PRE_T1_DIV
) (
  aclk,
  aresetn,
  run,
  tick_t1,
  tick_t4,
  tick_t16
);
  input  wire aclk;
  input  wire aresetn;
  input  wire run;
  output reg  tick_t1;
  output reg  tick_t4;
  output reg  tick_t16;

  reg  [7:0]  base_r;
  reg  [3:0]  div_r;
  wire        base_end;
  wire [31:0] base_lim;

  // last count of the base divider, cut to the counter width
  assign base_lim = BASE_DIV - 1;
  assign base_end = (base_r == base_lim[7:0]);

  // stopped prescaler holds at zero
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      base_r   <= 8'h00;
      div_r    <= 4'h0;
      tick_t1  <= 1'b0;
      tick_t4  <= 1'b0;
      tick_t16 <= 1'b0;
    end else begin
      tick_t1  <= base_end;
      tick_t4  <= base_end & (div_r[1:0] == 2'h3);
      tick_t16 <= base_end & (div_r == 4'hF);
      if (base_end) begin
        base_r <= 8'h00;
        div_r  <= div_r + 4'h1;
      end else begin
        base_r <= base_r + 8'h01;
      end
    end
  end
endmodule // prescaler_taps

// file: rtl/capture_pulse_timer_16b.v
`timescale 1ns/100ps
`include "capture_pulse_timer_defines.vh"
module capture_pulse_timer_16b #(
  parameter CNT_W    = 16,
  parameter BASE_DIV = `PRE_T1_DIV
) (
  aclk,
  aresetn,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  ext_count_trigger_input,
  pulse_output_pin,
  compare_b_match_irq,
  external_trigger_irq
);
  input  wire [7:0]  s_axi_awaddr;
  input  wire        aclk;
  input  wire        aresetn;
  input  wire        s_axi_awvalid;
  output reg         s_axi_awready;
  input  wire [31:0] s_axi_wdata;
  input  wire [3:0]  s_axi_wstrb;
  input  wire        s_axi_wvalid;
  output reg         s_axi_wready;
  output reg  [1:0]  s_axi_bresp;
  output reg         s_axi_bvalid;
  input  wire        s_axi_bready;
  input  wire [7:0]  s_axi_araddr;
  input  wire        s_axi_arvalid;
  output reg         s_axi_arready;
  output reg  [31:0] s_axi_rdata;
  output reg  [1:0]  s_axi_rresp;
  output reg         s_axi_rvalid;
  input  wire        s_axi_rready;
  input  wire        ext_count_trigger_input;
  output reg         pulse_output_pin;
  output reg         compare_b_match_irq;
  output reg         external_trigger_irq;
  reg  [7:0]       channel_run_register;
  reg  [7:0]       toggle_control_register;
  reg  [7:0]       channel_mode_register;
  reg  [CNT_W-1:0] compare_reg_a;
  reg  [CNT_W-1:0] compare_a_buf_r;
  reg  [CNT_W-1:0] compare_reg_b;
  reg  [CNT_W-1:0] up_counter;
  reg  [CNT_W-1:0] capture_reg_a;
  reg  [CNT_W-1:0] capture_reg_b;
  reg              output_toggle_ff;
  reg              match_b_seen_r;
  reg              trig_seen_r;
  reg              trig_prev_r;
  reg  [7:0]       aw_addr_r;
  reg              aw_have_r;
  reg  [31:0]      w_data_r;
  reg  [3:0]       w_strb_r;
  reg              w_have_r;
  reg              cnt_tick;
  reg              sw_cap_pulse;
  reg              ff_cmd_clr;
  reg              ff_cmd_set;
  reg              clr_seen_b;
  reg              clr_seen_t;
  wire             trig_level;
  wire             trig_rise;
  wire             tick_t1;
  wire             tick_t4;
  wire             tick_t16;
  wire             wr_go;
  wire             counter_run;
  wire             toggle_a;
  wire             toggle_b;
  wire             match_a;
  wire             match_b;
  wire [1:0]       clk_sel;
  // byte-lane merge for register writes
  function [7:0] merge8;
    input [7:0] old;
    input [7:0] nw;
    input       en;
    begin
      merge8 = en ? nw : old;
    end
  endfunction
  // address decode check
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a[1:0] == 2'h0) && (a <= `OFS_STATUS);
    end
  endfunction
  input_sync_edge u_trig (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (ext_count_trigger_input),
    .level   (trig_level),
    .rise    (trig_rise)
  );
  prescaler_taps #(
    .BASE_DIV (BASE_DIV)
  ) u_pre (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (channel_run_register[`RUN_PRE_BIT]),
    .tick_t1  (tick_t1),
    .tick_t4  (tick_t4),
    .tick_t16 (tick_t16)
  );
  assign clk_sel     = channel_mode_register[`MODE_CLK_HI:`MODE_CLK_LO];
  assign counter_run = channel_run_register[`RUN_CNT_BIT] &
                       channel_run_register[`RUN_PRE_BIT];
  assign toggle_a    = toggle_control_register[`FFCR_TGA_BIT];
  assign toggle_b    = toggle_control_register[`FFCR_TGB_BIT];
  assign match_a     = cnt_tick & (up_counter == compare_reg_a);
  assign match_b     = cnt_tick & (up_counter == compare_reg_b);
  assign wr_go       = aw_have_r & w_have_r & ~s_axi_bvalid;
  // counter clock source select
  always @* begin
    case (clk_sel)
      `CLK_EXT: cnt_tick = trig_rise;
      `CLK_T1:  cnt_tick = tick_t1;
      `CLK_T4:  cnt_tick = tick_t4;
      `CLK_T16: cnt_tick = tick_t16;
      default:  cnt_tick = 1'b0;
    endcase
    cnt_tick = cnt_tick & counter_run;
  end
  // write side effects decoded combinationally
  always @* begin
    sw_cap_pulse = 1'b0;
    ff_cmd_clr   = 1'b0;
    ff_cmd_set   = 1'b0;
    clr_seen_b   = 1'b0;
    clr_seen_t   = 1'b0;
    if (wr_go && w_strb_r[0]) begin
      if (aw_addr_r == `OFS_MODE)
        sw_cap_pulse = ~w_data_r[`MODE_SWCAP_BIT];
      if (aw_addr_r == `OFS_FFCR) begin
        ff_cmd_clr = (w_data_r[1:0] == `FFCR_CMD_CLR);
        ff_cmd_set = (w_data_r[1:0] == `FFCR_CMD_SET);
      end
      if (aw_addr_r == `OFS_STATUS) begin
        clr_seen_b = w_data_r[0];
        clr_seen_t = w_data_r[1];
      end
    end
  end
  // axi write channel: capture address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_have_r & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_r & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r     <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r     <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // register file writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_run_register    <= `RST_RUN;
      toggle_control_register <= `RST_FFCR;
      channel_mode_register   <= `RST_MODE;
      compare_a_buf_r         <= `RST_CMP;
      compare_reg_b           <= `RST_CMP;
    end else if (wr_go) begin
      case (aw_addr_r)
        `OFS_RUN:  channel_run_register <=
          merge8(channel_run_register, w_data_r[7:0] & 8'h85,
                 w_strb_r[0]);
        `OFS_FFCR: toggle_control_register <=
          merge8(toggle_control_register,
                 {3'h0, w_data_r[4:2], 2'h3}, w_strb_r[0]);
        `OFS_MODE: channel_mode_register <=
          merge8(channel_mode_register, w_data_r[7:0] & 8'h17,
                 w_strb_r[0]);
        `OFS_CMPA: begin
          if (w_strb_r[0]) compare_a_buf_r[7:0]  <= w_data_r[7:0];
          if (w_strb_r[1]) compare_a_buf_r[15:8] <= w_data_r[15:8];
        end
        `OFS_CMPB: begin
          if (w_strb_r[0]) compare_reg_b[7:0]  <= w_data_r[7:0];
          if (w_strb_r[1]) compare_reg_b[15:8] <= w_data_r[15:8];
        end
        default: ;
      endcase
    end
  end
  // compare A: direct, or loaded at B match when double buffered and the counter runs
  always @(posedge aclk) begin
    if (!aresetn)
      compare_reg_a <= `RST_CMP;
    else if (!channel_run_register[`RUN_DBUF_BIT] ||
             !channel_run_register[`RUN_CNT_BIT] || match_b)
      compare_reg_a <= compare_a_buf_r;
  end
  // up-counter, captures, flip-flop and events
  always @(posedge aclk) begin
    if (!aresetn) begin
      up_counter       <= {CNT_W{1'b0}};
      capture_reg_a    <= {CNT_W{1'b0}};
      capture_reg_b    <= {CNT_W{1'b0}};
      output_toggle_ff <= 1'b0;
      match_b_seen_r   <= 1'b0;
      trig_seen_r      <= 1'b0;
      trig_prev_r      <= 1'b0;
    end else begin
      if (!channel_run_register[`RUN_CNT_BIT])
        up_counter <= {CNT_W{1'b0}};
      else if (match_b && channel_mode_register[`MODE_CLE_BIT])
        up_counter <= {CNT_W{1'b0}};
      else if (cnt_tick)
        up_counter <= up_counter +
                      {{(CNT_W-1){1'b0}}, 1'b1};
      if (sw_cap_pulse)
        capture_reg_a <= up_counter;
      else if (trig_rise && channel_mode_register[`MODE_TRIG_BIT])
        capture_reg_a <= up_counter;
      if (!trig_level && trig_prev_r && // falling edge of synced pin
          channel_mode_register[`MODE_TRIG_BIT])
        capture_reg_b <= up_counter;
      if (ff_cmd_clr)
        output_toggle_ff <= 1'b0;
      else if (ff_cmd_set)
        output_toggle_ff <= 1'b1;
      else if ((match_a & toggle_a) ^ (match_b & toggle_b) ^
               (trig_rise & channel_mode_register[`MODE_TRIG_BIT] &
                toggle_control_register[`FFCR_TGCAP_BIT]))
        output_toggle_ff <= ~output_toggle_ff;
      match_b_seen_r <= match_b | (match_b_seen_r & ~clr_seen_b);
      trig_seen_r    <= trig_rise | (trig_seen_r & ~clr_seen_t);
      trig_prev_r    <= trig_level;
    end
  end
  // registered outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_output_pin     <= 1'b0;
      compare_b_match_irq  <= 1'b0;
      external_trigger_irq <= 1'b0;
    end else begin
      pulse_output_pin     <= output_toggle_ff;
      compare_b_match_irq  <= match_b;
      external_trigger_irq <= trig_rise;
    end
  end
  // axi read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= is_mapped(s_axi_araddr) ? `RESP_OKAY
                                                 : `RESP_SLVERR;
        case (s_axi_araddr)
          `OFS_RUN:    s_axi_rdata <= {24'h0, channel_run_register};
          `OFS_FFCR:   s_axi_rdata <= {24'h0, toggle_control_register};
          `OFS_MODE:   s_axi_rdata <= {24'h0, channel_mode_register};
          `OFS_CMPA:   s_axi_rdata <= {16'h0, compare_a_buf_r};
          `OFS_CMPB:   s_axi_rdata <= {16'h0, compare_reg_b};
          `OFS_CAPA:   s_axi_rdata <= {16'h0, capture_reg_a};
          `OFS_CAPB:   s_axi_rdata <= {16'h0, capture_reg_b};
          `OFS_COUNT:  s_axi_rdata <= {16'h0, up_counter};
          `OFS_STATUS: s_axi_rdata <= {29'h0, output_toggle_ff,
                                       trig_seen_r, match_b_seen_r};
          default:     s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // capture_pulse_timer_16b

// file: sim/capture_pulse_timer_16b_sva.sv
`timescale 1ns/100ps
// port-level checks on the timer channel
module capture_pulse_timer_16b_sva #(
  parameter CNT_W    = 16,
  parameter BASE_DIV = 8
) (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        ext_count_trigger_input,
  input wire        pulse_output_pin,
  input wire        compare_b_match_irq,
  input wire        external_trigger_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address and data taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_wr_err;
    s_wr_take ##0 (s_axi_awaddr > 8'h20) |-> ##2 s_axi_bresp == 2'h2;
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("bad write response");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_resp;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_rd_err;
    s_rd_take ##0 (s_axi_araddr > 8'h20)
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("bad read response");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_irq_b;
    compare_b_match_irq |=> !compare_b_match_irq;
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("b pulse long");
  property p_trig;
    $rose(ext_count_trigger_input) |-> ##[1:5] external_trigger_irq;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not seen");
endmodule // capture_pulse_timer_16b_sva

bind capture_pulse_timer_16b capture_pulse_timer_16b_sva #(
  .CNT_W(CNT_W), .BASE_DIV(BASE_DIV)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ext_count_trigger_input(ext_count_trigger_input),
  .pulse_output_pin(pulse_output_pin),
  .compare_b_match_irq(compare_b_match_irq),
  .external_trigger_irq(external_trigger_irq));

// file: sim/event_trigger_source.sv
`timescale 1ns/100ps
// external event and trigger source, line rests low
module event_trigger_source (
  input  wire aclk,
  output reg  pin
);
  initial pin = 1'b0;
  // n active-high pulses, high held three clocks, low four between pulses
  task automatic edges(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge aclk);
        pin <= 1'b1;
        repeat (3) @(posedge aclk);
        pin <= 1'b0;
        repeat (3) @(posedge aclk);
      end
    end
  endtask
endmodule // event_trigger_source

// file: sim/capture_pulse_timer_16b_tb.sv
`timescale 1ns/100ps
`include "capture_pulse_timer_defines.vh"
module capture_pulse_timer_16b_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdv;
  logic [1:0]  rrs, wrs;
  wire         awready, wready, bvalid, arready, rvalid, ext;
  wire         pin_out, irq_b, irq_t;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  integer      bad_count, check_count, i, hi, ed, nb, c0, c;
  logic        prev;
  // reset reads: address, response, data
  logic [41:0] rrow [0:5] = '{{`OFS_RUN, 2'h0, 32'h0},
    {`OFS_FFCR, 2'h0, 32'h3}, {`OFS_MODE, 2'h0, 32'h0},
    {`OFS_CMPA, 2'h0, 32'hFFFF}, {`OFS_CMPB, 2'h0, 32'hFFFF},
    {8'h24, 2'h2, 32'h0}};
  // wave rows: compare A, toggle control, high cycles, edges
  logic [31:0] prow [0:3] = '{32'h030E8008, 32'h010EC008,
    32'h010D4008, 32'h010A8004};
  capture_pulse_timer_16b #(.CNT_W(16), .BASE_DIV(`PRE_T1_DIV)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_count_trigger_input(ext),
    .pulse_output_pin(pin_out), .compare_b_match_irq(irq_b),
    .external_trigger_irq(irq_t));
  event_trigger_source src (.aclk(aclk), .pin(ext));
  task automatic check(input string what, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("unexpected %s: expected %h seen %h", what, e, g);
      end
    end
  endtask
  // one write, held until each channel is taken
  task automatic wr(input [7:0] a, input [31:0] d);
    logic aw, w, b;
    integer n;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      b = 1'b1;
      n = 0;
      while (b && n < 200) begin
        @(posedge aclk);
        n = n + 1;
        if (aw && awready) begin
          aw = 1'b0;
          awvalid <= 1'b0;
        end
        if (w && wready) begin
          w = 1'b0;
          wvalid <= 1'b0;
        end
        if (bvalid === 1'b1) begin
          b = 1'b0;
          bready <= 1'b0;
          wrs = bresp;
        end
      end
      check("write answer", 0, b);
    end
  endtask
  // one read, data taken at the answering edge
  task automatic rd(input [7:0] a);
    logic ar, r;
    integer n;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      ar = 1'b1;
      r = 1'b1;
      n = 0;
      while (r && n < 200) begin
        @(posedge aclk);
        n = n + 1;
        if (ar && arready) begin
          ar = 1'b0;
          arvalid <= 1'b0;
        end
        if (rvalid === 1'b1) begin
          r = 1'b0;
          rready <= 1'b0;
          rdv = rdata;
          rrs = rresp;
        end
      end
      check("read answer", 0, r);
    end
  endtask
  task automatic end_of_test;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // free-running clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // hang guard
  initial begin
    #1000000;
    bad_count = bad_count + 1;
    end_of_test;
  end
  // main sequence
  initial begin
    bad_count = 0;
    check_count = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      rd(rrow[i][41:34]);
      check("reset data", rrow[i][31:0], rdv);
      check("read resp", rrow[i][33:32], rrs);
    end
    wr(8'h24, 32'h0);
    check("write resp", 2'h2, wrs);
    $display("test reset and map done");
    wr(`OFS_MODE, 32'h0);
    wr(`OFS_RUN, 32'h1);
    src.edges(3);
    rd(`OFS_COUNT);
    check("count without prescaler", 0, rdv);
    wr(`OFS_RUN, 32'h5);
    src.edges(5);
    repeat (4) @(posedge aclk);
    wr(`OFS_MODE, 32'h0);
    rd(`OFS_CAPA);
    check("event capture", 5, rdv);
    $display("test event count done");
    for (i = 1; i < 4; i = i + 1) begin
      wr(`OFS_RUN, 32'h0);
      wr(`OFS_MODE, i);
      wr(`OFS_RUN, 32'h5);
      repeat (16 * (`PRE_T1_DIV << (2 * i - 2))) @(posedge aclk);
      rd(`OFS_COUNT);
      check("tap count", 1, rdv >= 15 && rdv <= 17);
    end
    $display("test clock taps done");
    wr(`OFS_CMPB, 32'h7);
    wr(`OFS_MODE, 32'h5);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`OFS_RUN, 32'h0);
      wr(`OFS_CMPA, prow[i][31:24]);
      wr(`OFS_FFCR, prow[i][23:16]);
      repeat (2) @(posedge aclk);
      check("pin after command", prow[i][16], pin_out);
      wr(`OFS_RUN, 32'h5);
      repeat (32) @(posedge aclk);
      {hi, ed, nb} = 0;
      prev = pin_out;
      repeat (256) begin
        @(posedge aclk);
        hi = hi + (pin_out === 1'b1);
        ed = ed + (pin_out !== prev);
        nb = nb + (irq_b === 1'b1);
        prev = pin_out;
      end
      check("high cycles", prow[i][15:8], hi);
      check("pin edges", prow[i][7:0], ed);
      check("match pulses", 4, nb);
    end
    $display("test pulse wave done");
    wr(`OFS_RUN, 32'h0);
    wr(`OFS_FFCR, 32'h2);
    wr(`OFS_MODE, 32'h11);
    wr(`OFS_RUN, 32'h5);
    repeat (40) @(posedge aclk);
    rd(`OFS_COUNT);
    c0 = rdv;
    src.edges(1);
    rd(`OFS_CAPA);
    c = rdv;
    check("trigger capture", 1, c >= c0 && c <= c0 + 2);
    wr(`OFS_CMPA, c + 6);
    wr(`OFS_CMPB, c + 8);
    wr(`OFS_FFCR, 32'hC);
    hi = 0;
    nb = 0;
    while (irq_b !== 1'b1 && nb < 200) begin
      @(posedge aclk);
      hi = hi + (pin_out === 1'b1);
      nb = nb + 1;
    end
    check("b match irq", 1, irq_b);
    repeat (4) begin
      @(posedge aclk);
      hi = hi + (pin_out === 1'b1);
    end
    wr(`OFS_FFCR, 32'h0);
    check("one-shot width", 16, hi);
    check("pin after shot", 0, pin_out);
    $display("test one-shot done");
    end_of_test;
  end
endmodule // capture_pulse_timer_16b_tb
